// ===== rtl/brs_pkg.sv
// Summary of operation
// RULE_01 - brown-out detection asserts whole-device reset pulse
// RULE_02 - clock source chosen from configuration fields
// RULE_03 - oscillator mode: clock held until start-up timer
// RULE_04 - with PLL, clock held until lock reads one
// RULE_05 - power-up delay runs alongside, then reset releases
// RULE_06 - zero delay with crystal: fail-safe delay instead
// RULE_07 - brown-out sets status flag bit one
// RULE_08 - detection stays active in sleep and idle
// RULE_09 - execution held 20 us after power-up, resume
// RULE_10 - status flag cleared only by software writing zero
package brs_pkg;
	// clock and timing
	localparam int CLK_PERIOD_NS   = 100;
	localparam int REG_START_NS    = 20000;  // regulator start delay, 20 us
	localparam int FAILSAFE_NS     = 100000; // fail-safe start delay, 100 us
	localparam int REG_START_CYC   = (REG_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int FAILSAFE_CYC    = (FAILSAFE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int OST_CYC         = 1024;   // oscillator start-up timer length
	localparam int TMR_W           = 16;
	localparam logic [TMR_W-1:0] REG_START_LOAD = TMR_W'(REG_START_CYC);
	localparam logic [TMR_W-1:0] FAILSAFE_LOAD  = TMR_W'(FAILSAFE_CYC);
	localparam logic [TMR_W-1:0] OST_LOAD       = TMR_W'(OST_CYC);
	localparam logic [TMR_W-1:0] NO_WAIT_LOAD   = 16'h0000;
	localparam logic [TMR_W-1:0] POWER_UP_TIMER_RESET     = 16'h0040;

	// register byte offsets
	localparam logic [7:0] RESET_CONTROL_REG_OFS  = 8'h00; // reset_control_reg
	localparam logic [7:0] OSCC_OFS  = 8'h04; // osc_control_reg
	localparam logic [7:0] POWER_UP_TIMER_OFS  = 8'h08; // power_up_delay register

	// field positions
	localparam int BOR_FLAG_BIT = 1;
	localparam int LOCK_BIT     = 5;
	localparam int CLK_RDY_BIT  = 6;

	// new_osc_select_cfg encodings
	localparam logic [2:0] NOSC_FRC      = 3'h0;
	localparam logic [2:0] NOSC_FRC_PLL  = 3'h1;
	localparam logic [2:0] NOSC_PRI      = 3'h2;
	localparam logic [2:0] NOSC_PRI_PLL  = 3'h3;
	// primary_osc_mode_cfg encodings
	localparam logic [1:0] POSC_EC  = 2'h0;
	localparam logic [1:0] POSC_XT  = 2'h1;
	localparam logic [1:0] POSC_HS  = 2'h2;
	localparam logic [1:0] POSC_OFF = 2'h3;

	typedef enum logic [1:0] {
		ST_RUN    = 2'b00,
		ST_PULSE  = 2'b01,
		ST_LAUNCH = 2'b10,
		ST_WAIT   = 2'b11
	} brs_state_t;

	typedef enum logic [1:0] {
		IDX_NONE = 2'b00,
		IDX_RESET_CONTROL_REG = 2'b01,
		IDX_OSCC = 2'b10,
		IDX_POWER_UP_TIMER = 2'b11
	} brs_idx_t;
endpackage

// ===== rtl/brs_dly_if.sv
`timescale 1ns/100ps
// start/load/done of one delay timer
interface brs_dly_if;
	logic        start;
	logic [15:0] load;
	logic        done;
	modport tmr (input start, input load, output done);
	modport ctl (output start, output load, input done);
endinterface

// ===== rtl/brs_timer.sv
`timescale 1ns/100ps
// one-shot down counter: done rises load+1 edges after start and stays until next start
module brs_timer import brs_pkg::*; (
	input  wire logic clk,
	input  wire logic rst,
	brs_dly_if.tmr    dly
);
	typedef struct packed {
		logic [TMR_W-1:0] cnt;
		logic             busy;
		logic             done;
	} brs_tmr_t;

	brs_tmr_t r_reg;
	brs_tmr_t r_next;

	// count down, restart on start
	always_comb begin
		r_next = r_reg;
		if (dly.start) begin
			r_next.cnt  = dly.load;
			r_next.busy = 1'b1;
			r_next.done = 1'b0;
		end else if (r_reg.busy) begin
			if (r_reg.cnt == NO_WAIT_LOAD) begin
				r_next.busy = 1'b0;
				r_next.done = 1'b1;
			end else begin
				r_next.cnt = r_reg.cnt - 16'h0001;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			r_reg <= '0;
		end else begin
			r_reg <= r_next;
		end
	end

	assign dly.done = r_reg.done;

	a_tmr_restart: assert property (@(posedge clk) disable iff (rst)
		dly.start |=> !dly.done) else $error("timer done not cleared by start");
endmodule // brs_timer

// ===== rtl/brs_sequencer.sv
`timescale 1ns/100ps
// brown-out reset sequencer with AHB-Lite register slave
module brs_sequencer import brs_pkg::*; (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        brownout_det,
	input  wire logic        pll_lock_in,
	input  wire logic        power_down,
	input  wire logic [2:0]  new_osc_select_cfg,
	input  wire logic [1:0]  primary_osc_mode_cfg,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	output logic             device_reset,
	output logic             sys_clk_en,
	output logic      [2:0]  clk_src_sel,
	output logic             code_exec_en
);
	typedef struct packed {
		brs_state_t       state;
		logic             bor_s1;
		logic             bor_s2;
		logic             lock_s1;
		logic             lock_s2;
		logic             pd_s1;
		logic             pd_s2;
		logic             pd_q;
		logic             por_q;
		logic             bor_flag;
		logic             clk_ready;
		logic [2:0]       src_sel;
		logic [TMR_W-1:0] power_up_timer_val;
		logic             wr_pend;
		brs_idx_t         wr_idx;
		logic [31:0]      rdata;
	} brs_seq_t;

	brs_seq_t r_reg;
	brs_seq_t r_next;

	brs_dly_if clk_dly ();
	brs_dly_if power_up_timer_dly ();
	brs_dly_if reg_dly ();

	logic     pll_used;
	logic     osc_mode;
	logic     crystal;
	logic     addr_ok;
	brs_idx_t addr_idx;

	// clock source properties from configuration fields
	assign pll_used = (new_osc_select_cfg == NOSC_FRC_PLL) || (new_osc_select_cfg == NOSC_PRI_PLL);
	assign osc_mode = ((new_osc_select_cfg == NOSC_PRI) || (new_osc_select_cfg == NOSC_PRI_PLL))
	                  && (primary_osc_mode_cfg != POSC_OFF);
	assign crystal  = osc_mode && ((primary_osc_mode_cfg == POSC_XT) || (primary_osc_mode_cfg == POSC_HS));

	// clock and power-up timers start when the sequence is launched; the regulator timer starts on power-up or wake
	assign clk_dly.start  = (r_reg.state == ST_LAUNCH);
	assign clk_dly.load   = osc_mode ? OST_LOAD : NO_WAIT_LOAD;           // see RULE_03
	assign power_up_timer_dly.start = (r_reg.state == ST_LAUNCH);                    // see RULE_05
	assign power_up_timer_dly.load  = (r_reg.power_up_timer_val == NO_WAIT_LOAD && crystal) ? FAILSAFE_LOAD
	                        : r_reg.power_up_timer_val;                              // see RULE_06
	assign reg_dly.start  = r_reg.por_q || (r_reg.pd_q && !r_reg.pd_s2);   // see RULE_09
	assign reg_dly.load   = REG_START_LOAD;

	brs_timer u_clk_tmr  (.clk(clk), .rst(rst), .dly(clk_dly));
	brs_timer u_power_up_timer_tmr (.clk(clk), .rst(rst), .dly(power_up_timer_dly));
	brs_timer u_reg_tmr  (.clk(clk), .rst(rst), .dly(reg_dly));

	// address phase decode
	always_comb begin
		addr_ok  = hsel && htrans[1] && hready;
		addr_idx = IDX_NONE;
		if (haddr[7:0] == RESET_CONTROL_REG_OFS) begin
			addr_idx = IDX_RESET_CONTROL_REG;
		end else if (haddr[7:0] == OSCC_OFS) begin
			addr_idx = IDX_OSCC;
		end else if (haddr[7:0] == POWER_UP_TIMER_OFS) begin
			addr_idx = IDX_POWER_UP_TIMER;
		end
	end

	// next state of sequencer and register file
	always_comb begin
		r_next         = r_reg;
		r_next.bor_s1  = brownout_det;
		r_next.bor_s2  = r_reg.bor_s1;
		r_next.lock_s1 = pll_lock_in;
		r_next.lock_s2 = r_reg.lock_s1;
		r_next.pd_s1   = power_down;
		r_next.pd_s2   = r_reg.pd_s1;
		r_next.pd_q    = r_reg.pd_s2;
		r_next.por_q   = 1'b0;

		// data phase write; clearing the flag needs a zero in its bit
		r_next.wr_pend = 1'b0;
		if (r_reg.wr_pend) begin
			if (r_reg.wr_idx == IDX_RESET_CONTROL_REG && !hwdata[BOR_FLAG_BIT]) begin
				r_next.bor_flag = 1'b0;                                // see RULE_10
			end else if (r_reg.wr_idx == IDX_POWER_UP_TIMER) begin
				r_next.power_up_timer_val = hwdata[TMR_W-1:0];
			end
		end

		// sequencer; detection is never gated by sleep or idle
		case (r_reg.state)
			ST_RUN: begin
				if (r_reg.bor_s2) begin
					r_next.state = ST_PULSE;                           // see RULE_01 see RULE_08
				end
			end
			ST_PULSE: begin
				r_next.clk_ready = 1'b0;
				r_next.bor_flag  = 1'b1;                               // see RULE_07
				if (!r_reg.bor_s2) begin
					r_next.state = ST_LAUNCH;
				end
			end
			ST_LAUNCH: begin
				r_next.src_sel = new_osc_select_cfg;                   // see RULE_02
				r_next.state   = ST_WAIT;
			end
			ST_WAIT: begin
				r_next.clk_ready = clk_dly.done && (!pll_used || r_reg.lock_s2); // see RULE_03 see RULE_04
				if (r_reg.bor_s2) begin
					r_next.state = ST_PULSE;                           // see RULE_08
				end else if (power_up_timer_dly.done && r_reg.clk_ready) begin
					r_next.state = ST_RUN;                             // see RULE_05
				end
			end
			default: begin
				r_next.state = ST_PULSE;
			end
		endcase

		// read data registered in the address phase
		if (addr_ok) begin
			r_next.wr_pend = hwrite;
			r_next.wr_idx  = addr_idx;
			r_next.rdata   = 32'h0000_0000;
			if (!hwrite) begin
				if (addr_idx == IDX_RESET_CONTROL_REG) begin
					r_next.rdata[BOR_FLAG_BIT] = r_reg.bor_flag;
				end else if (addr_idx == IDX_OSCC) begin
					r_next.rdata[2:0]         = r_reg.src_sel;
					r_next.rdata[LOCK_BIT]    = r_reg.lock_s2;
					r_next.rdata[CLK_RDY_BIT] = r_reg.clk_ready;
				end else if (addr_idx == IDX_POWER_UP_TIMER) begin
					r_next.rdata[TMR_W-1:0] = r_reg.power_up_timer_val;
				end
			end
		end
	end

	// state register
	always_ff @(posedge clk) begin
		if (rst) begin
			r_reg          <= '0;
			r_reg.state    <= ST_LAUNCH;
			r_reg.por_q    <= 1'b1;
			r_reg.src_sel  <= NOSC_FRC;
			r_reg.power_up_timer_val <= POWER_UP_TIMER_RESET;
		end else begin
			r_reg <= r_next;
		end
	end

	// outputs
	assign hrdata       = r_reg.rdata;
	assign hreadyout    = 1'b1;
	assign hresp        = 1'b0;
	assign device_reset = (r_reg.state != ST_RUN);                     // see RULE_01
	assign sys_clk_en   = r_reg.clk_ready;
	assign clk_src_sel  = r_reg.src_sel;
	// pd_q blocks the cycle before the regulator timer restart clears its stale done
	assign code_exec_en = (r_reg.state == ST_RUN) && reg_dly.done && !r_reg.pd_s2 && !r_reg.pd_q; // see RULE_09

	// checks
	sequence s_release;
		r_reg.state == ST_WAIT ##1 r_reg.state == ST_RUN;
	endsequence
	sequence s_bor_seen;
		r_reg.state == ST_RUN && r_reg.bor_s2;
	endsequence

	a_bor_reset_entry: assert property (@(posedge clk) disable iff (rst) // see RULE_01
		s_bor_seen |=> device_reset && r_reg.state == ST_PULSE) else $error("brown-out did not reset");
	a_src_select: assert property (@(posedge clk) disable iff (rst) // see RULE_02
		r_reg.state == ST_LAUNCH ##1 r_reg.state == ST_WAIT |-> clk_src_sel == $past(new_osc_select_cfg))
		else $error("clock source not taken from configuration");
	a_ost_hold: assert property (@(posedge clk) disable iff (rst) // see RULE_03
		$rose(sys_clk_en) |-> $past(clk_dly.done)) else $error("clock ungated before start-up timer");
	a_pll_lock: assert property (@(posedge clk) disable iff (rst) // see RULE_04
		$rose(sys_clk_en) && pll_used |-> $past(r_reg.lock_s2)) else $error("clock ungated before lock");
	a_power_up_timer_release: assert property (@(posedge clk) disable iff (rst) // see RULE_05
		s_release |-> $past(power_up_timer_dly.done) && sys_clk_en) else $error("reset released early");
	a_failsafe_load: assert property (@(posedge clk) disable iff (rst) // see RULE_06
		power_up_timer_dly.start && crystal && r_reg.power_up_timer_val == NO_WAIT_LOAD |-> power_up_timer_dly.load == FAILSAFE_LOAD)
		else $error("fail-safe delay not applied");
	a_flag_set: assert property (@(posedge clk) disable iff (rst) // see RULE_07
		r_reg.state == ST_PULSE |=> r_reg.bor_flag) else $error("brown-out flag not set");
	a_bor_in_wait: assert property (@(posedge clk) disable iff (rst) // see RULE_08
		r_reg.state == ST_WAIT && r_reg.bor_s2 |=> r_reg.state == ST_PULSE) else $error("brown-out missed");
	a_exec_hold: assert property (@(posedge clk) disable iff (rst) // see RULE_09
		reg_dly.start |=> !code_exec_en [*8]) else $error("execution enabled during regulator start");
	a_flag_sticky: assert property (@(posedge clk) disable iff (rst) // see RULE_10
		r_reg.bor_flag && !(r_reg.wr_pend && r_reg.wr_idx == IDX_RESET_CONTROL_REG) |=> r_reg.bor_flag)
		else $error("brown-out flag lost without software clear");
endmodule // brs_sequencer

// ===== dv/brs_sequencer_tb.sv
`timescale 1ns/100ps
module brs_sequencer_tb import brs_pkg::*;;
	logic        clk;
	logic        rst;
	logic        brownout_det;
	logic        pll_lock_in;
	logic        power_down;
	logic [2:0]  nosc;
	logic [1:0]  posc;
	logic        hsel;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [31:0] hwdata;
	logic        hready;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	logic        device_reset;
	logic        sys_clk_en;
	logic [2:0]  clk_src_sel;
	logic        code_exec_en;
	logic [31:0] rdat;
	int          errors;
	int          compares;
	int          n;

	brs_sequencer u_dut (.clk(clk), .rst(rst), .brownout_det(brownout_det), .pll_lock_in(pll_lock_in),
		.power_down(power_down), .new_osc_select_cfg(nosc), .primary_osc_mode_cfg(posc), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .device_reset(device_reset),
		.sys_clk_en(sys_clk_en), .clk_src_sel(clk_src_sel), .code_exec_en(code_exec_en));

	// single slave, so its ready is the bus ready
	assign hready = hreadyout;

	always #50 clk = ~clk;

	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			errors++;
			$display("unexpected %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic rng(input string nm, input int lo, input int hi, input int v);
		compares++;
		if (v < lo || v > hi) begin
			errors++;
			$display("unexpected %s expected %0d..%0d seen %0d", nm, lo, hi, v);
		end
	endtask

	// one single-word ahb transfer, address phase then data phase
	task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		@(posedge clk);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= wr;
		@(posedge clk);
		while (hready !== 1'b1) @(posedge clk);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwrite <= 1'b0;
		hwdata <= d;
		@(posedge clk);
		while (hready !== 1'b1) @(posedge clk);
		q = hrdata;
	endtask

	task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] exp);
		xfer(1'b0, a, 32'h0, rdat);
		chk(nm, exp, rdat);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		xfer(1'b1, a, d, rdat);
	endtask

	// counts edges until a watched output reaches the wanted level
	task automatic count_until(input logic sel_exec, output int c);
		c = 0;
		while (((sel_exec ? code_exec_en : !device_reset) !== 1'b1) && c < 3000) begin
			@(posedge clk);
			#1;
			c++;
		end
	endtask

	// brown-out held for some cycles, reset and gated clock checked meanwhile
	task automatic bor();
		@(posedge clk);
		brownout_det <= 1'b1;
		repeat (6) @(posedge clk);
		#1;
		chk("device_reset", 32'h1, {31'h0, device_reset});
		chk("sys_clk_en", 32'h0, {31'h0, sys_clk_en});
		@(posedge clk);
		brownout_det <= 1'b0;
	endtask

	task automatic run_bor(input string nm, input int lo, input int hi, input logic [2:0] src);
		bor();
		count_until(1'b0, n);
		rng(nm, lo, hi, n);
		chk("clk_src_sel", {29'h0, src}, {29'h0, clk_src_sel});
		chk("sys_clk_en", 32'h1, {31'h0, sys_clk_en});
		$display("done %s", nm);
	endtask

	task automatic test_reset();
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		#1;
		chk("code_exec_en", 32'h0, {31'h0, code_exec_en});
		count_until(1'b1, n);
		rng("regulator wait", 200, 206, n);
		chk("hresp", 32'h0, {31'h0, hresp});
		rd_chk("power_up_delay", POWER_UP_TIMER_OFS, 32'h40);
		rd_chk("status", RESET_CONTROL_REG_OFS, 32'h0);
		wr(OSCC_OFS, 32'hffffffff);
		rd_chk("osc_control", OSCC_OFS, 32'h60);
		rd_chk("unmapped", 8'h0c, 32'h0);
		$display("done reset");
	endtask

	task automatic test_flag();
		rd_chk("status", RESET_CONTROL_REG_OFS, 32'h2);
		wr(RESET_CONTROL_REG_OFS, 32'h2);
		rd_chk("status", RESET_CONTROL_REG_OFS, 32'h2);
		wr(RESET_CONTROL_REG_OFS, 32'h0);
		rd_chk("status", RESET_CONTROL_REG_OFS, 32'h0);
		$display("done flag");
	endtask

	task automatic test_pll();
		nosc <= NOSC_PRI_PLL;
		pll_lock_in <= 1'b0;
		bor();
		repeat (1200) @(posedge clk);
		#1;
		chk("device_reset", 32'h1, {31'h0, device_reset});
		chk("sys_clk_en", 32'h0, {31'h0, sys_clk_en});
		@(posedge clk);
		pll_lock_in <= 1'b1;
		count_until(1'b0, n);
		rng("lock release", 1, 8, n);
		chk("clk_src_sel", 32'h3, {29'h0, clk_src_sel});
		rd_chk("osc_control", OSCC_OFS, 32'h63);
		$display("done pll");
	endtask

	task automatic test_sleep();
		@(posedge clk);
		power_down <= 1'b1;
		repeat (20) @(posedge clk);
		run_bor("sleep bor", 64, 74, 3'h0);
		rd_chk("status", RESET_CONTROL_REG_OFS, 32'h2);
		@(posedge clk);
		power_down <= 1'b0;
		count_until(1'b1, n);
		rng("resume wait", 200, 206, n);
		$display("done sleep");
	endtask

	initial begin
		clk = 1'b0;
		rst = 1'b1;
		brownout_det = 1'b0;
		pll_lock_in = 1'b1;
		power_down = 1'b0;
		nosc = NOSC_FRC;
		posc = POSC_EC;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hwdata = 32'h0;
		errors = 0;
		compares = 0;
		test_reset();
		wr(POWER_UP_TIMER_OFS, 32'h80);
		run_bor("power-up delay", 128, 138, 3'h0);
		test_flag();
		nosc <= NOSC_PRI;
		posc <= POSC_HS;
		run_bor("start-up timer", 1024, 1034, 3'h2);
		posc <= POSC_EC;
		test_pll();
		wr(POWER_UP_TIMER_OFS, 32'h0);
		nosc <= NOSC_PRI;
		posc <= POSC_XT;
		run_bor("fail-safe", 1024, 1034, 3'h2);
		nosc <= NOSC_FRC_PLL;
		posc <= POSC_EC;
		run_bor("no delay", 0, 8, 3'h1);
		wr(POWER_UP_TIMER_OFS, 32'h40);
		nosc <= NOSC_FRC;
		test_sleep();
		results();
	end

	// watchdog: the whole run takes well under this span
	initial begin
		repeat (20000) @(posedge clk);
		errors++;
		$display("unexpected watchdog expected finish seen timeout");
		results();
	end

	task automatic results();
		$display("compares %0d errors %0d", compares, errors);
		if (errors == 0 && compares > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
endmodule // brs_sequencer_tb
